// ---- dv/host_port_properties.sv ----
// Concurrent checks on the link between the two ends of the host port
`timescale 1ns/1ns
`include "hp_defines.svh"
module host_port_properties #(
   parameter int INIT_CYC = 4
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic req,
   input wire logic write,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic ack,
   input wire logic [7:0] rdata,
   input wire logic host_request_line_n
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);
   ////////////////////////////////////////
   // Cycles since the last acknowledged write that set the init bit
   logic [5:0] init_age_r;
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         init_age_r <= 6'h3F;
      end else if (ack && write && addr == `A_CTRL && wdata[`CTRL_INIT]) begin
         init_age_r <= 6'h00;
      end else if (init_age_r != 6'h3F) begin
         init_age_r <= init_age_r + 6'h01;
      end
   end
   ////////////////////////////////////////
   sequence s_open;
      $rose(req) ##1 req;
   endsequence
   sequence s_grant;
      ##[1:8] ack;
   endsequence
   sequence s_late_ctrl_read;
      ack && !write && addr == `A_CTRL && int'(init_age_r) > INIT_CYC + 8;
   endsequence
   a_ack_in_bound: assert property (s_open |-> s_grant)
      else $error("ack late after request");
   a_ack_has_cause: assert property ($rose(ack) |-> $past(req, 1) && $past(req, 2))
      else $error("ack without a held request");
   a_ack_stands: assert property (ack && req |=> ack)
      else $error("ack dropped while request held");
   a_req_stands: assert property (req && !ack |=> req)
      else $error("request dropped before ack");
   a_qual_stable: assert property (req && $past(req) |-> $stable({write, addr, wdata}))
      else $error("access changed while requested");
   a_rdata_stable: assert property (ack && $past(ack) |-> $stable(rdata))
      else $error("read data moved under ack");
   a_ack_drop_bound: assert property ($fell(req) |-> ##[1:8] !ack)
      else $error("ack not released");
   a_init_self_clear: assert property (s_late_ctrl_read |-> !rdata[`CTRL_INIT])
      else $error("init bit never cleared");
   c_request_low: cover property (!host_request_line_n);
endmodule

// ---- dv/host_port_sync_rules_tb_top.sv ----
// Self-checking bench joining both ends of the host port
`timescale 1ns/1ns
`include "hp_defines.svh"
module host_port_sync_rules_tb_top;
   localparam int INIT_CYC = 4;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic cmd_valid = 1'b0;
   logic cmd_write = 1'b0;
   logic [2:0] cmd_addr = 3'h0;
   logic [7:0] cmd_wdata = 8'h00;
   logic cmd_ready;
   logic rsp_valid;
   logic rsp_refused;
   logic [7:0] rsp_data;
   logic init_done;
   logic request_seen;
   logic [23:0] rx_word;
   logic rx_valid;
   logic rx_ready = 1'b1;
   logic [23:0] tx_word = 24'h000000;
   logic tx_valid = 1'b0;
   logic tx_ready;
   logic hf2 = 1'b0;
   logic hf3 = 1'b0;
   logic cmd_exc;
   logic [4:0] cmd_vec;
   logic [5:0] host_status;
   logic [1:0] flag_pair;
   logic op_refused;
   logic [7:0] op_data;
   int err_total = 0;
   int checks = 0;
   int exc_count = 0;
   hp_pkg::word_t exp_q[$];
   host_link_if host_link_if_i();
   host_end host_end_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .link(host_link_if_i),
      .cmd_valid_in(cmd_valid), .cmd_write_in(cmd_write), .cmd_addr_in(cmd_addr),
      .cmd_wdata_in(cmd_wdata), .cmd_ready_out(cmd_ready), .rsp_valid_out(rsp_valid),
      .rsp_refused_out(rsp_refused), .rsp_data_out(rsp_data), .init_done_out(init_done),
      .request_seen_out(request_seen));
   dsp_end #(.INIT_CYC(INIT_CYC)) dsp_end_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .link(host_link_if_i), .rx_word_out(rx_word), .rx_valid_out(rx_valid),
      .rx_ready_in(rx_ready), .tx_word_in(tx_word), .tx_valid_in(tx_valid),
      .tx_ready_out(tx_ready), .host_flag_two_in(hf2), .host_flag_three_in(hf3),
      .cmd_exception_out(cmd_exc), .cmd_vector_out(cmd_vec), .host_status_out(host_status),
      .flag_pair_out(flag_pair));
   host_port_properties #(.INIT_CYC(INIT_CYC)) host_port_properties_i (.clk_in(clk_in),
      .sys_rst_in(sys_rst_in), .req(host_link_if_i.req), .write(host_link_if_i.write),
      .addr(host_link_if_i.addr), .wdata(host_link_if_i.wdata), .ack(host_link_if_i.ack),
      .rdata(host_link_if_i.rdata), .host_request_line_n(host_link_if_i.host_request_line_n));
   ////////////////////////////////////////
   always #20 clk_in = ~clk_in;
   task automatic step;
      @(posedge clk_in);
      #1;
   endtask
   task automatic check(input logic ok, input string msg);
      checks++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask
   task automatic finish_test;
      if (err_total == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic host_op(input logic wr, input logic [2:0] a, input logic [7:0] d);
      for (int n = 0; n < 200 && cmd_ready !== 1'b1; n++) step;
      cmd_valid = 1'b1;
      cmd_write = wr;
      cmd_addr = a;
      cmd_wdata = d;
      step;
      cmd_valid = 1'b0;
      for (int n = 0; n < 200 && rsp_valid !== 1'b1; n++) step;
      check(rsp_valid, "no response");
      op_refused = rsp_refused;
      op_data = rsp_data;
   endtask
   // Three byte accesses, upper first, lower last
   task automatic host_word(input logic wr, inout hp_pkg::word_t w);
      for (int b = 2; b >= 0; b--) begin
         host_op(wr, 3'(`A_TX_LOWER - b), w[8*b +: 8]);
         if (!wr) w[8*b +: 8] = op_data;
      end
   endtask
   ////////////////////////////////////////
   always @(negedge clk_in) begin
      if (cmd_exc === 1'b1) exc_count++;
      if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
         check(exp_q.size() > 0 && rx_word === exp_q[0], "received word");
         if (exp_q.size() > 0) void'(exp_q.pop_front());
      end
   end
   // Whole sequence needs under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk_in);
      err_total++;
      finish_test;
   end
   initial begin
      hp_pkg::word_t w;
      hp_pkg::word_t r;
      logic [4:0] v;
      logic [7:0] c;
      logic full;
      int e0;
      void'($urandom(32'hC804));
      repeat (8) step;
      sys_rst_in = 1'b0;
      for (int n = 0; n < 600 && init_done !== 1'b1; n++) step;
      check(init_done === 1'b1, "boot never ended");
      check(request_seen === 1'b1, "request line idle");
      host_op(1'b0, `A_CTRL, 8'h00);
      check(op_data[`CTRL_INIT] === 1'b0, "init bit stuck");
      check(op_data[1:0] === 2'b11, "request enables lost");
      host_op(1'b0, 3'h3, 8'h00);
      check(op_refused === 1'b0, "unmapped read refused");
      // Receiver stalled: send until the host refuses
      rx_ready = 1'b0;
      full = 1'b0;
      for (int i = 0; i < 6 && !full; i++) begin
         host_op(1'b0, `A_STAT, 8'h00);
         if (op_data[`STAT_TXE] === 1'b1) begin
            w = hp_pkg::word_t'($urandom());
            host_word(1'b1, w);
            exp_q.push_back(w);
         end else begin
            host_op(1'b1, `A_TX_UPPER, 8'h5A);
            check(op_refused === 1'b1, "write to full bytes taken");
            full = 1'b1;
         end
      end
      check(full && exp_q.size() >= 2, "no refusal or short buffer");
      rx_ready = 1'b1;
      for (int n = 0; n < 60 && exp_q.size() > 0; n++) step;
      check(exp_q.size() == 0, "words lost");
      host_op(1'b0, `A_STAT, 8'h00);
      host_op(1'b0, `A_TX_LOWER, 8'h00);
      check(op_refused === 1'b1, "early byte read taken");
      for (int k = 0; k < 3; k++) begin
         w = hp_pkg::word_t'($urandom());
         tx_word = w;
         tx_valid = 1'b1;
         for (int n = 0; n < 50 && tx_ready !== 1'b1; n++) step;
         step;
         tx_valid = 1'b0;
         op_data = 8'h00;
         for (int n = 0; n < 10 && op_data[`STAT_RXF] !== 1'b1; n++) host_op(1'b0, `A_STAT, 8'h00);
         check(op_data[`STAT_RXF] === 1'b1, "receive-full never set");
         r = 24'h000000;
         host_word(1'b0, r);
         check(r === w, "host read word");
         host_op(1'b0, `A_STAT, 8'h00);
         check(op_data[`STAT_RXF] === 1'b0, "receive-full not cleared");
      end
      v = 5'($urandom());
      e0 = exc_count;
      host_op(1'b1, `A_CMD, {3'h4, v});
      for (int n = 0; n < 30 && exc_count == e0; n++) step;
      check(exc_count == e0 + 1 && cmd_vec === v, "command not taken");
      host_op(1'b0, `A_CMD, 8'h00);
      check(op_data[`CMD_HC] === 1'b0, "command bit not cleared");
      v = ~v;
      e0 = exc_count;
      host_op(1'b1, `A_CMD, {3'h4, v});
      host_op(1'b1, `A_CMD, {3'h0, v});
      repeat (30) step;
      check(exc_count - e0 <= 1, "cancelled command taken twice");
      check(exc_count == e0 || cmd_vec === v, "stray vector");
      host_op(1'b0, `A_CMD, 8'h00);
      check(op_data[`CMD_HC] === 1'b0, "cancel lost");
      for (int k = 0; k < 4; k++) begin
         c = 8'h03;
         c[`CTRL_HF0] = k[0];
         c[`CTRL_HF1] = k[1];
         c[`CTRL_DMA] = 1'($urandom());
         {hf3, hf2} = 2'($urandom());
         host_op(1'b1, `A_CTRL, c);
         repeat (6) step;
         check(flag_pair === 2'(k), "flag pair");
         check(host_status[5:3] === {c[`CTRL_DMA], 2'(k)}, "host bits");
         check(host_status[2:0] === 3'b010, "idle host bits");
         host_op(1'b0, `A_STAT, 8'h00);
         check(op_data[`STAT_HF2] === hf2 && op_data[`STAT_HF3] === hf3, "device flags");
      end
      finish_test;
   end
endmodule

// ---- inc/host_link_if.sv ----
// Parallel host link between the host processor and the device
`timescale 1ns/1ns
interface host_link_if;
   logic req;
   logic write;
   logic [2:0] addr;
   logic [7:0] wdata;
   logic ack;
   logic [7:0] rdata;
   logic host_request_line_n;

   modport host_mp (
      output req,
      output write,
      output addr,
      output wdata,
      input ack,
      input rdata,
      input host_request_line_n
   );

   modport dsp_mp (
      input req,
      input write,
      input addr,
      input wdata,
      output ack,
      output rdata,
      output host_request_line_n
   );
endinterface

// ---- inc/hp_defines.svh ----
// Offsets, field positions, reset values and counts of the host port
`ifndef HP_DEFINES_SVH
`define HP_DEFINES_SVH

`define ADDR_W 3
`define BYTE_W 8
`define WORD_W 24
`define VEC_W 5
`define SYNC_DEPTH 2

`define A_CTRL 3'h0
`define A_CMD 3'h1
`define A_STAT 3'h2
`define A_TX_UPPER 3'h5
`define A_TX_MIDDLE 3'h6
`define A_TX_LOWER 3'h7

`define CTRL_RECEIVE_REQUEST_ENABLE 0
`define CTRL_TRANSMIT_REQUEST_ENABLE 1
`define CTRL_HF0 3
`define CTRL_HF1 4
`define CTRL_DMA 5
`define CTRL_INIT 7

`define CMD_HC 7
`define CMD_VEC_LO 0

`define STAT_RXF 0
`define STAT_TXE 1
`define STAT_TRANSMITTER_READY 2
`define STAT_HF2 3
`define STAT_HF3 4
`define STAT_DMA 6
`define STAT_HOST_REQUEST_LINE 7

`define CTRL_RESET 8'h00
`define CMD_RESET 8'h00
`define VEC_RESET 5'h00
`define INIT_CYCLES 4
`define BOOT_CTRL 8'h83

`endif

// ---- inc/hp_pkg.sv ----
// Types shared by both ends of the host port
package hp_pkg;
   typedef logic [23:0] word_t;
   typedef logic [7:0] byte_t;

   typedef enum logic [1:0] {
      D_IDLE = 2'b01,
      D_HOLD = 2'b10
   } dsp_state_t;

   typedef enum logic [4:0] {
      H_BOOT = 5'b00001,
      H_SETUP = 5'b00010,
      H_REQ = 5'b00100,
      H_DROP = 5'b01000,
      H_IDLE = 5'b10000
   } host_state_t;

   typedef enum logic [3:0] {
      P_WR = 4'b0001,
      P_POLL = 4'b0010,
      P_STAT = 4'b0100,
      P_USER = 4'b1000
   } host_phase_t;
endpackage

// ---- rtl/dsp_end.sv ----
// Device end of the host port: host registers, data path and status crossing
//
// Notes on behaviour
// - Host reads receive bytes only when full
// - Host writes transmit bytes only when empty
// - Transmit bytes move into the device receive path
// - Device drives the status bits the host reads
// - Host tolerates status caught mid-change
// - Host changes vector only while command clear
// - Host may clear command to cancel it
// - Device may still take a cancelled command
// - Host never changes vector when clearing command
// - Host waits for port setup before bootstrap
// - Host sets init, polls it, reads status
// - Device clears init when setup is done
// - Alternative: write request enables with init
// - Host-side bits cross to device individually
// - Flag pair accepted only when two reads agree
`timescale 1ns/1ns
`include "hp_defines.svh"
module dsp_end #(
   parameter int INIT_CYC = `INIT_CYCLES
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   host_link_if.dsp_mp link,
   output logic [23:0] rx_word_out,
   output logic rx_valid_out,
   input wire logic rx_ready_in,
   input wire logic [23:0] tx_word_in,
   input wire logic tx_valid_in,
   output logic tx_ready_out,
   input wire logic host_flag_two_in,
   input wire logic host_flag_three_in,
   output logic cmd_exception_out,
   output logic [4:0] cmd_vector_out,
   output logic [5:0] host_status_out,
   output logic [1:0] flag_pair_out
);
   ////////////////////////////////////////////////////////////////////////
   // Link pins through two flip-flops
   logic [12:0] pin_m_r;
   logic [12:0] pin_s_r;
   logic req_s;
   logic wr_s;
   logic [2:0] addr_s;
   logic [7:0] wdata_s;

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         pin_m_r <= '0;
         pin_s_r <= '0;
      end else begin
         pin_m_r <= {link.req, link.write, link.addr, link.wdata};
         pin_s_r <= pin_m_r;
      end
   end
   assign {req_s, wr_s, addr_s, wdata_s} = pin_s_r;

   ////////////////////////////////////////////////////////////////////////
   // Four-phase handshake
   hp_pkg::dsp_state_t state_r;
   logic access;
   logic ack_r;
   logic [7:0] rdata_r;

   assign access = (state_r == hp_pkg::D_IDLE) && req_s;

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_r <= hp_pkg::D_IDLE;
         ack_r <= 1'b0;
      end else begin
         case (state_r)
            hp_pkg::D_IDLE: begin
               if (req_s) begin
                  state_r <= hp_pkg::D_HOLD;
                  ack_r <= 1'b1;
               end
            end
            hp_pkg::D_HOLD: begin
               if (!req_s) begin
                  state_r <= hp_pkg::D_IDLE;
                  ack_r <= 1'b0;
               end
            end
            default: begin
               state_r <= hp_pkg::D_IDLE;
               ack_r <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Host-visible registers
   logic [7:0] ctrl_r;
   logic hc_r;
   logic [4:0] vec_r;
   logic [23:0] tx_bytes_r;
   logic [23:0] rx_bytes_r;
   logic txe_r;
   logic rxf_r;
   logic tx_pend_r;
   logic [7:0] init_cnt_r;
   logic take;
   logic buf_in_ready;
   logic wr_ctrl;
   logic wr_cmd;
   logic wr_lower;
   logic rd_lower;
   logic host_request_line;
   logic transmitter_ready;

   assign wr_ctrl = access && wr_s && (addr_s == `A_CTRL);
   assign wr_cmd = access && wr_s && (addr_s == `A_CMD);
   assign wr_lower = access && wr_s && (addr_s == `A_TX_LOWER);
   assign rd_lower = access && !wr_s && (addr_s == `A_TX_LOWER);

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         ctrl_r <= `CTRL_RESET;
         init_cnt_r <= '0;
      end else if (wr_ctrl) begin
         ctrl_r <= wdata_s;
         init_cnt_r <= wdata_s[`CTRL_INIT] ? 8'(INIT_CYC) : 8'h00;
      end else if (init_cnt_r != '0) begin
         init_cnt_r <= init_cnt_r - 8'h01;
         if (init_cnt_r == 8'h01) begin
            ctrl_r[`CTRL_INIT] <= 1'b0;
         end
      end
   end

   // Device clears on take; a host write in the same cycle wins
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         hc_r <= 1'b0;
         vec_r <= `VEC_RESET;
      end else begin
         if (take) begin
            hc_r <= 1'b0;
         end
         if (wr_cmd) begin
            hc_r <= wdata_s[`CMD_HC];
            vec_r <= wdata_s[`CMD_VEC_LO +: 5];
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         tx_bytes_r <= '0;
      end else if (access && wr_s) begin
         case (addr_s)
            `A_TX_UPPER: tx_bytes_r[23:16] <= wdata_s;
            `A_TX_MIDDLE: tx_bytes_r[15:8] <= wdata_s;
            `A_TX_LOWER: tx_bytes_r[7:0] <= wdata_s;
            default: tx_bytes_r <= tx_bytes_r;
         endcase
      end
   end

   // Transmit bytes hand over to the device receive buffer
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         tx_pend_r <= 1'b0;
         txe_r <= 1'b1;
      end else if (wr_lower) begin
         tx_pend_r <= 1'b1;
         txe_r <= 1'b0;
      end else if (tx_pend_r && buf_in_ready) begin
         tx_pend_r <= 1'b0;
         txe_r <= 1'b1;
      end
   end

   assign tx_ready_out = !rxf_r;

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         rx_bytes_r <= '0;
         rxf_r <= 1'b0;
      end else if (tx_valid_in && !rxf_r) begin
         rx_bytes_r <= tx_word_in;
         rxf_r <= 1'b1;
      end else if (rd_lower) begin
         rxf_r <= 1'b0;
      end
   end

   pair_buffer #(
      .WIDTH(24),
      .DEPTH(2)
   ) u_rx_buf (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .in_valid_in(tx_pend_r),
      .in_ready_out(buf_in_ready),
      .in_data_in(tx_bytes_r),
      .out_valid_out(rx_valid_out),
      .out_ready_in(rx_ready_in),
      .out_data_out(rx_word_out)
   );

   ////////////////////////////////////////////////////////////////////////
   // Read data and request line
   assign transmitter_ready = txe_r && !rx_valid_out;
   assign host_request_line = (ctrl_r[`CTRL_TRANSMIT_REQUEST_ENABLE] && rxf_r) || (ctrl_r[`CTRL_RECEIVE_REQUEST_ENABLE] && txe_r);

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         rdata_r <= 8'h00;
      end else if (access && !wr_s) begin
         case (addr_s)
            `A_CTRL: rdata_r <= ctrl_r;
            `A_CMD: rdata_r <= {hc_r, 2'b00, vec_r};
            `A_STAT: begin
               rdata_r <= 8'h00;
               rdata_r[`STAT_RXF] <= rxf_r;
               rdata_r[`STAT_TXE] <= txe_r;
               rdata_r[`STAT_TRANSMITTER_READY] <= transmitter_ready;
               rdata_r[`STAT_HF2] <= host_flag_two_in;
               rdata_r[`STAT_HF3] <= host_flag_three_in;
               rdata_r[`STAT_DMA] <= ctrl_r[`CTRL_DMA];
               rdata_r[`STAT_HOST_REQUEST_LINE] <= host_request_line;
            end
            `A_TX_UPPER: rdata_r <= rx_bytes_r[23:16];
            `A_TX_MIDDLE: rdata_r <= rx_bytes_r[15:8];
            `A_TX_LOWER: rdata_r <= rx_bytes_r[7:0];
            default: rdata_r <= 8'h00;
         endcase
      end
   end

   logic host_request_line_n_r;
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         host_request_line_n_r <= 1'b1;
      end else begin
         host_request_line_n_r <= !host_request_line;
      end
   end

   assign link.ack = ack_r;
   assign link.rdata = rdata_r;
   assign link.host_request_line_n = host_request_line_n_r;

   ////////////////////////////////////////////////////////////////////////
   // Host-side bits cross one by one to the device side
   logic [5:0] hbits;
   logic [5:0] hb_m_r;
   logic [5:0] hb_s_r;
   assign hbits = {ctrl_r[`CTRL_DMA], ctrl_r[`CTRL_HF1], ctrl_r[`CTRL_HF0],
                   hc_r, !rxf_r, !txe_r};

   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_bit_sync
         always_ff @(posedge clk_in) begin
            if (sys_rst_in) begin
               hb_m_r[gi] <= 1'b0;
               hb_s_r[gi] <= 1'b0;
            end else begin
               hb_m_r[gi] <= hbits[gi];
               hb_s_r[gi] <= hb_m_r[gi];
            end
         end
      end
   endgenerate
   assign host_status_out = hb_s_r;

   ////////////////////////////////////////////////////////////////////////
   // Command exception, taken from the delayed pending bit
   logic taken_r;
   logic exc_r;
   logic [4:0] cvec_r;
   assign take = hb_s_r[2] && !taken_r;

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         taken_r <= 1'b0;
         exc_r <= 1'b0;
         cvec_r <= `VEC_RESET;
      end else begin
         exc_r <= take;
         if (take) begin
            taken_r <= 1'b1;
            cvec_r <= vec_r;
         end else if (!hb_s_r[2]) begin
            taken_r <= 1'b0;
         end
      end
   end
   assign cmd_exception_out = exc_r;
   assign cmd_vector_out = cvec_r;

   ////////////////////////////////////////////////////////////////////////
   // Flag pair read twice, accepted on agreement
   logic [1:0] pair_prev_r;
   logic [1:0] pair_r;
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         pair_prev_r <= 2'h0;
         pair_r <= 2'h0;
      end else begin
         pair_prev_r <= hb_s_r[4:3];
         if (pair_prev_r == hb_s_r[4:3]) begin
            pair_r <= hb_s_r[4:3];
         end
      end
   end
   assign flag_pair_out = pair_r;
endmodule

// ---- rtl/host_end.sv ----
// Host processor end: boot sequence, guarded register access over the link
`timescale 1ns/1ns
`include "hp_defines.svh"
module host_end #(
   parameter logic [7:0] BOOT_CTRL = `BOOT_CTRL
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   host_link_if.host_mp link,
   input wire logic cmd_valid_in,
   input wire logic cmd_write_in,
   input wire logic [2:0] cmd_addr_in,
   input wire logic [7:0] cmd_wdata_in,
   output logic cmd_ready_out,
   output logic rsp_valid_out,
   output logic rsp_refused_out,
   output logic [7:0] rsp_data_out,
   output logic init_done_out,
   output logic request_seen_out
);
   ////////////////////////////////////////////////////////////////////////
   // Pins from the device through two flip-flops
   logic [9:0] pin_m_r;
   logic [9:0] pin_s_r;
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         pin_m_r <= 10'h200;
         pin_s_r <= 10'h200;
      end else begin
         pin_m_r <= {link.host_request_line_n, link.ack, link.rdata};
         pin_s_r <= pin_m_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Access sequencer
   hp_pkg::host_state_t state_r;
   hp_pkg::host_phase_t phase_r;
   logic req_r;
   logic wr_r;
   logic [2:0] addr_r;
   logic [7:0] wdata_r;
   logic [7:0] rd_r;
   logic rsp_r;
   logic ref_r;
   logic done_r;
   logic sh_rxf_r;
   logic sh_txe_r;
   logic sh_hc_r;
   logic [4:0] sh_vec_r;
   logic bad;
   logic [7:0] wsafe;

   assign cmd_ready_out = (state_r == hp_pkg::H_IDLE);

   // Refused: receive read when not full, transmit write when not empty
   always_comb begin
      bad = 1'b0;
      if (cmd_addr_in == `A_TX_LOWER || cmd_addr_in == `A_TX_MIDDLE ||
          cmd_addr_in == `A_TX_UPPER) begin
         bad = cmd_write_in ? !sh_txe_r : !sh_rxf_r;
      end
   end

   // While a command is pending the vector bits are kept as they are
   always_comb begin
      wsafe = cmd_wdata_in;
      if (cmd_addr_in == `A_CMD && sh_hc_r) begin
         wsafe[`CMD_VEC_LO +: 5] = sh_vec_r;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_r <= hp_pkg::H_BOOT;
         phase_r <= hp_pkg::P_WR;
         req_r <= 1'b0;
         wr_r <= 1'b0;
         addr_r <= 3'h0;
         wdata_r <= 8'h00;
         rd_r <= 8'h00;
         rsp_r <= 1'b0;
         ref_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         rsp_r <= 1'b0;
         ref_r <= 1'b0;
         case (state_r)
            hp_pkg::H_BOOT: begin
               wr_r <= 1'b1;
               addr_r <= `A_CTRL;
               wdata_r <= BOOT_CTRL;
               phase_r <= hp_pkg::P_WR;
               state_r <= hp_pkg::H_SETUP;
            end
            hp_pkg::H_SETUP: begin
               req_r <= 1'b1;
               state_r <= hp_pkg::H_REQ;
            end
            hp_pkg::H_REQ: begin
               if (pin_s_r[8]) begin
                  rd_r <= pin_s_r[7:0];
                  req_r <= 1'b0;
                  state_r <= hp_pkg::H_DROP;
               end
            end
            hp_pkg::H_DROP: begin
               if (!pin_s_r[8]) begin
                  case (phase_r)
                     hp_pkg::P_WR: begin
                        phase_r <= hp_pkg::P_POLL;
                        wr_r <= 1'b0;
                        state_r <= hp_pkg::H_SETUP;
                     end
                     hp_pkg::P_POLL: begin
                        if (!rd_r[`CTRL_INIT]) begin
                           phase_r <= hp_pkg::P_STAT;
                           addr_r <= `A_STAT;
                        end
                        state_r <= hp_pkg::H_SETUP;
                     end
                     hp_pkg::P_STAT: begin
                        done_r <= 1'b1;
                        phase_r <= hp_pkg::P_USER;
                        state_r <= hp_pkg::H_IDLE;
                     end
                     default: begin
                        rsp_r <= 1'b1;
                        state_r <= hp_pkg::H_IDLE;
                     end
                  endcase
               end
            end
            hp_pkg::H_IDLE: begin
               if (cmd_valid_in && bad) begin
                  rsp_r <= 1'b1;
                  ref_r <= 1'b1;
               end else if (cmd_valid_in) begin
                  wr_r <= cmd_write_in;
                  addr_r <= cmd_addr_in;
                  wdata_r <= wsafe;
                  state_r <= hp_pkg::H_SETUP;
               end
            end
            default: state_r <= hp_pkg::H_BOOT;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status shadow, refreshed by finished status reads, command accesses and lower-byte accesses
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         sh_rxf_r <= 1'b0;
         sh_txe_r <= 1'b0;
         sh_hc_r <= 1'b0;
         sh_vec_r <= `VEC_RESET;
      end else if (state_r == hp_pkg::H_DROP && !pin_s_r[8]) begin
         if (!wr_r && addr_r == `A_STAT) begin
            sh_rxf_r <= rd_r[`STAT_RXF];
            sh_txe_r <= rd_r[`STAT_TXE];
         end
         if (addr_r == `A_CMD) begin
            sh_hc_r <= wr_r ? wdata_r[`CMD_HC] : rd_r[`CMD_HC];
            sh_vec_r <= wr_r ? wdata_r[`CMD_VEC_LO +: 5] : rd_r[`CMD_VEC_LO +: 5];
         end
         if (addr_r == `A_TX_LOWER) begin
            if (wr_r) begin
               sh_txe_r <= 1'b0;
            end else begin
               sh_rxf_r <= 1'b0;
            end
         end
      end
   end

   assign link.req = req_r;
   assign link.write = wr_r;
   assign link.addr = addr_r;
   assign link.wdata = wdata_r;
   assign rsp_valid_out = rsp_r;
   assign rsp_refused_out = ref_r;
   assign rsp_data_out = rd_r;
   assign init_done_out = done_r;
   assign request_seen_out = !pin_s_r[9];
endmodule

// ---- rtl/pair_buffer.sv ----
// Two-entry valid/ready buffer
`timescale 1ns/1ns
module pair_buffer #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 2
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PW-1:0] wr_ptr_r;
   logic [PW-1:0] rd_ptr_r;
   logic [PW:0] count_r;
   logic push;
   logic pop;

   assign in_ready_out = (count_r != (PW+1)'(DEPTH));
   assign out_valid_out = (count_r != '0);
   assign out_data_out = mem_r[rd_ptr_r];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == PW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == PW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         end
         count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule
